// ==== include/boot_cfg_pkg.sv ====
// Package: constants and carriers for the dual-loop boot and bus-id block
package boot_cfg_pkg;

  // -------------------------------------------------------------------
  // Register offsets (plain port, byte-free index)
  // -------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_BOOT1 = 4'h2;
  localparam logic [3:0] REG_BOOT2 = 4'h3;
  localparam logic [3:0] REG_VOFS = 4'h4;
  localparam logic [3:0] REG_VMAX = 4'h5;
  localparam logic [3:0] REG_ROFS = 4'h6;
  localparam logic [3:0] REG_SLEW = 4'h7;
  localparam logic [3:0] REG_TOFS = 4'h8;
  localparam logic [3:0] REG_STAT = 4'h9;
  localparam logic [3:0] REG_L2DLY = 4'hA;
  localparam logic [3:0] REG_TGT = 4'hB;

  // -------------------------------------------------------------------
  // Control register bit positions
  // -------------------------------------------------------------------
  localparam int CTRL_GUARD = 0;
  localparam int CTRL_STRAP_EN = 1;
  localparam int CTRL_REV_NV = 2;
  localparam int CTRL_TRACK = 3;
  localparam int CTRL_HOSTSEL = 4;
  localparam int CTRL_FIXSEL_LO = 5;
  localparam int CTRL_FIXBOOT = 7;

  // -------------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [3:0] ADDR1_RESET = 4'h0;
  localparam logic [3:0] ADDR2_RESET = 4'h1;
  localparam logic [7:0] BOOT_RESET = 8'h00;
  localparam logic [7:0] VMAX_RESET = 8'hFF;
  localparam logic [7:0] SLEW_RESET = 8'h11;
  localparam logic [7:0] VID_OFF = 8'h00;
  localparam logic [3:0] STRAP_MAX = 4'hB;

  // Fixed later-revision boot codes: 0V, 1.65V, 1.7V, 1.75V
  localparam logic [7:0] FIX_BOOT0 = 8'h00;
  localparam logic [7:0] FIX_BOOT1 = 8'hE6;
  localparam logic [7:0] FIX_BOOT2 = 8'hF0;
  localparam logic [7:0] FIX_BOOT3 = 8'hFA;

  // -------------------------------------------------------------------
  // Timing (25 MHz clock)
  // -------------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int START_NS = 3000;
  localparam int START_CYC = START_NS * CLK_MHZ / 1000;
  localparam int READY_NS = 1000;
  localparam int READY_CYC = READY_NS * CLK_MHZ / 1000;
  localparam int L2STEP_PS = 2660000;
  localparam int L2STEP_CYC = (L2STEP_PS / 1000) * CLK_MHZ / 1000;
  localparam int L2DLY_MAX = 255;
  localparam int STEP_CYC_W = 8;

  // -------------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] target;
    logic power_good;
    logic ramping;
  } loop_state_type;

endpackage : boot_cfg_pkg

// ==== src/boot_sequencer.sv ====
// Dual-loop boot sequencer with bus-id configuration and offsets
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Operation
// RULE1 - Nonzero boot ramps rail, then ready
// RULE2 - Both nonzero loops start together
// RULE3 - Zero boot waits for addressed command
// RULE4 - Default bus addresses zero and one
// RULE5 - Address writable only while guard cleared
// RULE6 - Strap offset 0..11 added when enabled
// RULE7 - Signed output offset, one code steps
// RULE8 - Output clamped, never above maximum
// RULE9 - Current and temperature reporting offsets
// RULE10 - Later revision by bit or pin
// RULE11 - Later revision boot: register or fixed
// RULE12 - Tracking: loop 2 target half loop 1
// RULE13 - Tracking accepts either host kind
// RULE14 - Host sets loop 2 slew half
// RULE15 - Tracking: loop 1 starts after 3us
// RULE16 - Ready within 1us of ramp end
// RULE17 - Loop 2 delay in 2.66us steps; code steps are 66 cycles, 2.64us
// RULE18 - Boot codes stored, used each power-on
// RULE19 - Offset added, then clamped to maximum
module boot_sequencer
  import boot_cfg_pkg::*;
#(
  parameter int DLY_STEPS = L2DLY_MAX
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Pins
  input wire logic regulator_enable_input_i,
  input wire logic protocol_rev_select_pin_b_i,
  input wire logic [3:0] bus_id_strap_pin_i,
  // Voltage-ID bus command from decoder
  input wire logic vid_cmd_valid_i,
  input wire logic vid_cmd_from_host_i,
  input wire logic [3:0] vid_cmd_addr_i,
  input wire logic [7:0] vid_cmd_code_i,
  // Reporting values in and out
  input wire logic [7:0] current_raw_i,
  input wire logic [7:0] temp_raw_i,
  output logic [7:0] current_rpt_o,
  output logic [7:0] temp_rpt_o,
  // Loop outputs
  output logic [7:0] loop1_target_o,
  output logic [7:0] loop2_target_o,
  output logic loop1_power_good_o,
  output logic loop2_power_good_o,
  output logic [3:0] loop1_bus_addr_o,
  output logic [3:0] loop2_bus_addr_o,
  output logic later_rev_o
);

  initial begin
    if (DLY_STEPS < 1 || DLY_STEPS > L2DLY_MAX) $error("boot_sequencer: bad delay steps");
  end

  // -------------------------------------------------------------------
  // Synchronisers for pins
  // -------------------------------------------------------------------
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_q <= 6'h02; // Enable low, revision pin at its idle high
      pin_s2_q <= 6'h02;
    end else begin
      pin_s1_q <= {bus_id_strap_pin_i, protocol_rev_select_pin_b_i, regulator_enable_input_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic enable_s;
  logic rev_pin_b_s;
  logic [3:0] strap_s;
  assign enable_s = pin_s2_q[0];
  assign rev_pin_b_s = pin_s2_q[1];
  assign strap_s = pin_s2_q[5:2];

  // -------------------------------------------------------------------
  // Configuration registers (stand-in for nonvolatile store)
  // -------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] addr_q;
  logic [7:0] boot1_q;
  logic [7:0] boot2_q;
  logic [7:0] vofs_q;
  logic [7:0] vmax_q;
  logic [7:0] rofs_q;
  logic [7:0] tofs_q;
  logic [7:0] slew_q;
  logic [7:0] l2dly_q;
  reg_req_type req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // Register writes; address field obeys the guard
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= CTRL_RESET;
      addr_q <= {ADDR2_RESET, ADDR1_RESET}; // [RULE4]
      boot1_q <= BOOT_RESET;
      boot2_q <= BOOT_RESET;
      vofs_q <= VID_OFF;
      vmax_q <= VMAX_RESET;
      rofs_q <= 8'h00;
      tofs_q <= 8'h00;
      slew_q <= SLEW_RESET;
      l2dly_q <= 8'h00;
    end else if (req.wr) begin
      case (req.addr)
        REG_CTRL: ctrl_q <= req.wdata;
        REG_ADDR: if (!ctrl_q[CTRL_GUARD]) addr_q <= req.wdata; // [RULE5]
        REG_BOOT1: boot1_q <= req.wdata; // [RULE18]
        REG_BOOT2: boot2_q <= req.wdata; // [RULE18]
        REG_VOFS: vofs_q <= req.wdata; // [RULE7]
        REG_VMAX: vmax_q <= req.wdata;
        REG_ROFS: rofs_q <= req.wdata; // [RULE9]
        REG_TOFS: tofs_q <= req.wdata; // [RULE9]
        REG_SLEW: slew_q <= req.wdata; // [RULE14]
        REG_L2DLY: l2dly_q <= req.wdata; // [RULE17]
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Bus address with optional strap offset
  // -------------------------------------------------------------------
  function automatic logic [3:0] add_strap(input logic [3:0] base, input logic en,
                                           input logic [3:0] strap);
    logic [3:0] ofs;
    ofs = (strap > STRAP_MAX) ? STRAP_MAX : strap;
    add_strap = en ? base + ofs : base; // [RULE6]
  endfunction : add_strap

  assign loop1_bus_addr_o = add_strap(addr_q[3:0], ctrl_q[CTRL_STRAP_EN], strap_s);
  assign loop2_bus_addr_o = add_strap(addr_q[7:4], ctrl_q[CTRL_STRAP_EN], strap_s);

  // Bus path may always command; host path in tracking mode only
  logic cmd_ok;
  logic cmd_l1;
  logic cmd_l2;
  assign cmd_ok = vid_cmd_valid_i &&
                  (!vid_cmd_from_host_i || ctrl_q[CTRL_TRACK]); // [RULE13]
  assign cmd_l1 = cmd_ok && vid_cmd_addr_i == loop1_bus_addr_o;
  assign cmd_l2 = cmd_ok && vid_cmd_addr_i == loop2_bus_addr_o;

  // -------------------------------------------------------------------
  // Mode and boot code selection
  // -------------------------------------------------------------------
  assign later_rev_o = ctrl_q[CTRL_REV_NV] || !rev_pin_b_s; // [RULE10]

  function automatic logic [7:0] boot_pick(input logic [7:0] reg_code, input logic later,
                                           input logic fix, input logic [1:0] sel);
    logic [7:0] fixed;
    case (sel)
      2'd0: fixed = FIX_BOOT0;
      2'd1: fixed = FIX_BOOT1;
      2'd2: fixed = FIX_BOOT2;
      default: fixed = FIX_BOOT3;
    endcase
    boot_pick = (later && fix) ? fixed : reg_code; // [RULE11]
  endfunction : boot_pick

  logic [7:0] boot1_code;
  logic [7:0] boot2_code;
  assign boot1_code = boot_pick(boot1_q, later_rev_o, ctrl_q[CTRL_FIXBOOT],
                                ctrl_q[CTRL_FIXSEL_LO +: 2]);
  assign boot2_code = boot_pick(boot2_q, later_rev_o, ctrl_q[CTRL_FIXBOOT],
                                ctrl_q[CTRL_FIXSEL_LO +: 2]);

  // -------------------------------------------------------------------
  // Commanded codes: boot value at power-on, bus commands after
  // -------------------------------------------------------------------
  logic [7:0] cmd1_q;
  logic [7:0] cmd2_q;
  logic go1_q;
  logic go2_q;
  logic go1_d;
  logic go2_d;
  typedef enum logic [2:0] {S_OFF, S_LEAD, S_DLY2, S_RUN} seq_type;
  seq_type seq_q;
  logic [7:0] lead_q;
  logic [7:0] step_q;
  logic [7:0] dly_q;
  logic l2_tick;
  assign l2_tick = (step_q == 8'(L2STEP_CYC - 1));

  // Sequencer: common start, tracking lead time and loop 2 delay
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_q <= S_OFF;
      lead_q <= 8'h00;
      step_q <= 8'h00;
      dly_q <= 8'h00;
    end else begin
      step_q <= l2_tick ? 8'h00 : step_q + 8'h01;
      case (seq_q)
        S_OFF: begin
          if (enable_s) begin
            seq_q <= ctrl_q[CTRL_TRACK] ? S_LEAD : S_RUN;
            lead_q <= 8'h00;
          end
        end
        S_LEAD: begin
          lead_q <= lead_q + 8'h01;
          if (lead_q == 8'(START_CYC - 1)) begin
            seq_q <= (l2dly_q == 8'h00) ? S_RUN : S_DLY2; // [RULE15]
            step_q <= 8'h00;
            dly_q <= 8'h00;
          end
        end
        S_DLY2: begin
          if (l2_tick) begin
            dly_q <= dly_q + 8'h01;
            if (dly_q + 8'h01 >= l2dly_q) seq_q <= S_RUN; // [RULE17]
          end
        end
        S_RUN: ;
        default: seq_q <= S_OFF;
      endcase
      if (!enable_s) seq_q <= S_OFF;
    end
  end

  // Start events; zero boot waits for its own command (loop 2 in tracking goes by loop 1's boot code)
  always_comb begin
    go1_d = 1'b0;
    go2_d = 1'b0;
    if (seq_q == S_OFF && enable_s && !ctrl_q[CTRL_TRACK]) begin
      go1_d = boot1_code != VID_OFF; // [RULE1] [RULE2]
      go2_d = boot2_code != VID_OFF; // [RULE2]
    end else if (seq_q == S_LEAD && lead_q == 8'(START_CYC - 1)) begin
      go1_d = boot1_code != VID_OFF;
      go2_d = (l2dly_q == 8'h00) && boot1_code != VID_OFF;
    end else if (seq_q == S_DLY2 && l2_tick && dly_q + 8'h01 >= l2dly_q) begin
      go2_d = boot1_code != VID_OFF;
    end
    if (seq_q != S_OFF && cmd_l1) go1_d = 1'b1; // [RULE3]
    if (seq_q != S_OFF && cmd_l2) go2_d = 1'b1; // [RULE3]
  end

  // Commanded code per loop, loaded from boot store at power-on
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd1_q <= VID_OFF;
      cmd2_q <= VID_OFF;
      go1_q <= 1'b0;
      go2_q <= 1'b0;
    end else begin
      go1_q <= go1_d;
      go2_q <= go2_d;
      if (seq_q == S_OFF) begin
        cmd1_q <= boot1_code; // [RULE18]
        cmd2_q <= boot2_code;
      end else begin
        if (cmd_l1) cmd1_q <= vid_cmd_code_i;
        if (cmd_l2) cmd2_q <= vid_cmd_code_i;
      end
    end
  end

  // Offset then clamp to the programmed maximum
  function automatic logic [7:0] ofs_clamp(input logic [7:0] code, input logic [7:0] ofs,
                                           input logic [7:0] vmax);
    logic signed [9:0] sum;
    sum = $signed({2'b00, code}) + $signed({{2{ofs[7]}}, ofs});
    if (code == VID_OFF) ofs_clamp = VID_OFF;
    else if (sum > $signed({2'b00, vmax})) ofs_clamp = vmax; // [RULE8] [RULE19]
    else if (sum < 10'sd1) ofs_clamp = (vmax == VID_OFF) ? VID_OFF : 8'h01;
    else ofs_clamp = sum[7:0]; // [RULE7]
  endfunction : ofs_clamp

  logic [7:0] tgt1;
  logic [7:0] tgt2;
  assign tgt1 = ofs_clamp(cmd1_q, vofs_q, vmax_q);
  assign tgt2 = ctrl_q[CTRL_TRACK] ? {1'b0, tgt1[7:1]} : ofs_clamp(cmd2_q, vofs_q, vmax_q); // [RULE12]

  // -------------------------------------------------------------------
  // Slew dividers and loop engines
  // -------------------------------------------------------------------
  logic [1:0] slew_tick;
  logic [7:0] slew_cnt_q [2];
  loop_state_type lst [2];
  logic [7:0] tgts [2];
  logic [1:0] gos;
  assign tgts[0] = tgt1;
  assign tgts[1] = tgt2;
  assign gos = {go2_q, go1_q};

  for (genvar g = 0; g < 2; g++) begin : g_loop
    // Per-loop step rate from its own slew nibble
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        slew_cnt_q[g] <= 8'h00;
      end else if (slew_tick[g]) begin
        slew_cnt_q[g] <= 8'h00;
      end else begin
        slew_cnt_q[g] <= slew_cnt_q[g] + 8'h01;
      end
    end
    assign slew_tick[g] = slew_cnt_q[g] >= {4'h0, slew_q[4*g +: 4]}; // [RULE14]
    loop_ramp #(.READY_DLY(READY_CYC)) loop_ramp_i ( // [RULE16]
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .start_i(gos[g]),
      .step_en_i(slew_tick[g]),
      .target_i(tgts[g]),
      .state_o(lst[g])
    );
  end

  assign loop1_target_o = lst[0].target;
  assign loop2_target_o = lst[1].target;
  assign loop1_power_good_o = lst[0].power_good; // [RULE1]
  assign loop2_power_good_o = lst[1].power_good;

  // -------------------------------------------------------------------
  // Reporting offsets: current 0.25A and temperature 1C codes
  // -------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      current_rpt_o <= 8'h00;
      temp_rpt_o <= 8'h00;
    end else begin
      current_rpt_o <= current_raw_i + {{3{rofs_q[4]}}, rofs_q[4:0]}; // [RULE9]
      temp_rpt_o <= temp_raw_i + {{2{tofs_q[5]}}, tofs_q[5:0]}; // [RULE9]
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        REG_CTRL: reg_rdata_o <= ctrl_q;
        REG_ADDR: reg_rdata_o <= addr_q;
        REG_BOOT1: reg_rdata_o <= boot1_q;
        REG_BOOT2: reg_rdata_o <= boot2_q;
        REG_VOFS: reg_rdata_o <= vofs_q;
        REG_VMAX: reg_rdata_o <= vmax_q;
        REG_ROFS: reg_rdata_o <= rofs_q;
        REG_TOFS: reg_rdata_o <= tofs_q;
        REG_SLEW: reg_rdata_o <= slew_q;
        REG_STAT: reg_rdata_o <= {3'b000, later_rev_o, lst[1].ramping, lst[0].ramping,
                                  lst[1].power_good, lst[0].power_good};
        REG_L2DLY: reg_rdata_o <= l2dly_q;
        REG_TGT: reg_rdata_o <= tgt1;
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  a_addr_guard: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE5]
    ctrl_q[CTRL_GUARD] |=> addr_q == $past(addr_q))
    else $error("address changed while guard set");
  a_target_limit: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE8]
    tgt1 <= vmax_q)
    else $error("target above maximum");
  a_track_half: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE12]
    (ctrl_q[CTRL_TRACK] && lst[0].power_good && lst[1].power_good)
    |-> lst[1].target == {1'b0, lst[0].target[7:1]})
    else $error("loop 2 target not half of loop 1");
  a_zero_boot_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE3]
    (seq_q == S_OFF && !go1_q) |=> lst[0].target == $past(lst[0].target) || $past(go1_q))
    else $error("loop 1 moved without a start");
  a_both_start: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE2]
    (seq_q == S_OFF && enable_s && !ctrl_q[CTRL_TRACK] && boot1_code != VID_OFF
     && boot2_code != VID_OFF) |=> go1_q && go2_q)
    else $error("loops did not start together");
  a_lead_time: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE15]
    (seq_q == S_OFF && enable_s && ctrl_q[CTRL_TRACK]) |=> !go1_q [*8])
    else $error("loop 1 started before lead time");
  a_rev_select: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE10]
    !pin_s2_q[1] |-> later_rev_o)
    else $error("later revision not selected by pin");
  a_default_addr: assert property (@(posedge clock_i) disable iff (!rst_b_i) // [RULE4]
    $rose(rst_b_i) |-> addr_q == {ADDR2_RESET, ADDR1_RESET})
    else $error("default bus address wrong");

endmodule : boot_sequencer

// ==== src/loop_ramp.sv ====
// Loop ramp engine: steps the present VID code toward a target
`timescale 1ns/1ns
module loop_ramp
  import boot_cfg_pkg::*;
#(
  parameter int READY_DLY = READY_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Control
  input wire logic start_i,
  input wire logic step_en_i,
  input wire logic [7:0] target_i,
  // Status
  output loop_state_type state_o
);

  initial begin
    if (READY_DLY < 1) $error("loop_ramp: ready delay below one cycle");
  end

  logic [7:0] level_q;
  logic run_q;
  logic [7:0] rdy_cnt_q;
  logic good_q;

  // Walk one code per enable; rising only from the start event onward
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= VID_OFF;
      run_q <= 1'b0;
    end else begin
      if (start_i) begin
        run_q <= 1'b1;
      end
      if ((run_q || start_i) && step_en_i && level_q != target_i) begin
        level_q <= (level_q < target_i) ? level_q + 8'h01 : level_q - 8'h01; // [RULE1]
      end
    end
  end

  // Ready follows arrival; counter raises it READY_DLY cycles later, right at the bound
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdy_cnt_q <= 8'h00;
      good_q <= 1'b0;
    end else if (!run_q || level_q != target_i || target_i == VID_OFF) begin
      rdy_cnt_q <= 8'h00;
      good_q <= 1'b0;
    end else if (rdy_cnt_q < 8'(READY_DLY - 1)) begin
      rdy_cnt_q <= rdy_cnt_q + 8'h01;
    end else begin
      good_q <= 1'b1; // [RULE16]
    end
  end

  assign state_o.target = level_q;
  assign state_o.power_good = good_q;
  assign state_o.ramping = run_q && (level_q != target_i);

  // Ready drops at most one cycle after level and target part
  a_ready_settled: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    good_q |-> $past(level_q) == $past(target_i)) // [RULE16]
    else $error("ready asserted while not at target");

endmodule : loop_ramp

// ==== verif/boot_sequencer_tb.sv ====
// Self-checking bench for the dual-loop boot sequencer
`timescale 1ns/1ns
module boot_sequencer_tb;
  import boot_cfg_pkg::*;
  // -------
  // Signals
  // -------
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic rev_b = 1'b1;
  logic [3:0] strap = 4'h0;
  logic [7:0] cur_raw = 8'h00;
  logic [7:0] tmp_raw = 8'h00;
  logic cv, ch, pg1, pg2, later;
  logic [3:0] ca, a1, a2;
  logic [7:0] cc, rdata, cur_rpt, tmp_rpt, t1, t2;
  logic [31:0] seed = 32'h6e71;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int s1, s2;

  // Clock, 40 ns period
  initial forever #20 clock_i = ~clock_i;

  // ---------
  // Instances
  // ---------
  boot_sequencer boot_sequencer_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .regulator_enable_input_i(en), .protocol_rev_select_pin_b_i(rev_b),
    .bus_id_strap_pin_i(strap), .vid_cmd_valid_i(cv), .vid_cmd_from_host_i(ch),
    .vid_cmd_addr_i(ca), .vid_cmd_code_i(cc), .current_raw_i(cur_raw), .temp_raw_i(tmp_raw),
    .current_rpt_o(cur_rpt), .temp_rpt_o(tmp_rpt), .loop1_target_o(t1), .loop2_target_o(t2),
    .loop1_power_good_o(pg1), .loop2_power_good_o(pg2), .loop1_bus_addr_o(a1),
    .loop2_bus_addr_o(a2), .later_rev_o(later));
  vid_host_model vid_host_model_i (.clock_i(clock_i), .vid_cmd_valid_o(cv),
    .vid_cmd_from_host_o(ch), .vid_cmd_addr_o(ca), .vid_cmd_code_o(cc));

  // Hang guard; the longest run needs a few thousand cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  // ---------------
  // Helpers
  // ---------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Strap values above eleven saturate
  function automatic logic [3:0] strap_addr(input logic [3:0] b, input logic [3:0] s);
    return b + ((s > 4'hB) ? 4'hB : s);
  endfunction : strap_addr

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    tick();
    wr <= 1'b0;
    tick();
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input string nm);
    addr <= a;
    rd <= 1'b1;
    tick();
    rd <= 1'b0;
    chk(nm, e, rdata);
    tick();
  endtask : rreg

  task automatic reset_dut();
    rst_b_i <= 1'b0;
    en <= 1'b0;
    repeat (6) tick();
    rst_b_i <= 1'b1;
    tick();
  endtask : reset_dut

  // Enable and follow both ramps, noting both start cycles and loop 1 arrival and ready cycles
  task automatic boot_run(input logic [7:0] e1, input logic [7:0] e2, input logic c2,
                          output int b1, output int b2);
    int n, r1, p1;
    b1 = -1;
    b2 = -1;
    r1 = -1;
    p1 = -1;
    en <= 1'b1;
    for (n = 1; n < 1200 && !(pg1 === 1'b1 && (pg2 === 1'b1 || c2 !== 1'b1)); n++) begin
      tick();
      if (b1 < 0 && t1 !== 8'h00) b1 = n;
      if (b2 < 0 && t2 !== 8'h00) b2 = n;
      if (r1 < 0 && t1 === e1) r1 = n;
      if (p1 < 0 && pg1 === 1'b1) p1 = n;
    end
    chk("loop1_target", e1, t1);
    if (c2 === 1'b1) chk("loop2_target", e2, t2);
    if (c2 === 1'b1) chk("loop2_ready", 8'h01, {7'h00, pg2});
    chk("ready_delay", 8'h01, {7'h00, r1 > 0 && p1 >= r1 && p1 - r1 <= READY_CYC + 1});
  endtask : boot_run

  task automatic summarize();
    if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // --------------
  // Main sequence
  // --------------
  initial begin
    int i;
    logic [7:0] r, b, c, q;
    logic [3:0] s;
    reset_dut();
    chk("loop1_addr", 8'h00, {4'h0, a1});
    chk("loop2_addr", 8'h01, {4'h0, a2});
    chk("later_rev", 8'h00, {7'h00, later});
    rreg(REG_CTRL, CTRL_RESET, "ctrl");
    rreg(REG_VMAX, VMAX_RESET, "vmax");
    rreg(REG_SLEW, SLEW_RESET, "slew");
    rreg(4'hC, 8'h00, "unmapped");
    // Locked write ignored, then the unlock-write-lock sequence
    wreg(REG_ADDR, 8'h21);
    rreg(REG_ADDR, 8'h10, "addr_locked");
    wreg(REG_CTRL, 8'h00);
    wreg(REG_ADDR, 8'h21);
    wreg(REG_CTRL, 8'h01);
    rreg(REG_ADDR, 8'h21, "addr_open");
    // Strap offset, saturating corner first
    wreg(REG_CTRL, 8'h03);
    for (i = 0; i < 4; i++) begin
      s = (i == 0) ? 4'hF : 4'(rnd());
      strap <= s;
      repeat (3) tick();
      chk("strap_addr", {4'h0, strap_addr(4'h1, s)}, {4'h0, a1});
    end
    wreg(REG_CTRL, 8'h01);
    chk("no_strap", 8'h02, {4'h0, a2});
    // Revision select by pin and by bit
    rev_b <= 1'b0;
    repeat (3) tick();
    chk("rev_pin", 8'h01, {7'h00, later});
    rev_b <= 1'b1;
    repeat (3) tick();
    chk("rev_off", 8'h00, {7'h00, later});
    wreg(REG_CTRL, 8'h05);
    chk("rev_bit", 8'h01, {7'h00, later});
    // Reporting offsets, most negative current and temperature first
    for (i = 0; i < 4; i++) begin
      r = (i == 0) ? 8'h10 : 8'(rnd());
      q = (i == 0) ? 8'h20 : 8'(rnd());
      cur_raw <= 8'(rnd());
      tmp_raw <= 8'(rnd());
      wreg(REG_ROFS, r);
      wreg(REG_TOFS, q);
      chk("cur_rpt", cur_raw + {{3{r[4]}}, r[4:0]}, cur_rpt);
      chk("tmp_rpt", tmp_raw + {{2{q[5]}}, q[5:0]}, tmp_rpt);
    end
    // Offset pushes loop 1 past the limit; loop 2 stays below it
    reset_dut();
    b = 8'h10 + {4'h0, 4'(rnd())};
    wreg(REG_BOOT1, 8'h40);
    wreg(REG_BOOT2, b);
    wreg(REG_VOFS, 8'h10);
    wreg(REG_VMAX, 8'h48);
    boot_run(8'h48, b + 8'h10, 1'b1, s1, s2);
    chk("same_start", 8'h01, {7'h00, s1 == s2 && s1 > 0});
    // Zero boot on loop 2 waits for its own command
    reset_dut();
    wreg(REG_BOOT1, 8'h20);
    boot_run(8'h20, 8'h00, 1'b0, s1, s2);
    chk("idle_loop2", 8'h00, t2);
    vid_host_model_i.send(4'h5, 8'h18, 1'b0);
    repeat (20) tick();
    chk("wrong_addr", 8'h00, t2);
    c = 8'h08 + {4'h0, 4'(rnd())};
    vid_host_model_i.send(4'h1, c, 1'b0);
    repeat (60) tick();
    chk("cmd_loop2", c, t2);
    // Tracking mode with loop 2 slewing at half rate
    reset_dut();
    wreg(REG_SLEW, 8'h31);
    wreg(REG_L2DLY, 8'h01);
    wreg(REG_BOOT1, 8'h40);
    wreg(REG_BOOT2, 8'h20);
    wreg(REG_CTRL, 8'h09);
    boot_run(8'h40, 8'h20, 1'b1, s1, s2);
    chk("l1_start", 8'h01, {7'h00, s1 >= START_CYC && s1 <= START_CYC + 6});
    chk("l2_delay", 8'h01, {7'h00, s2 - s1 >= L2STEP_CYC && s2 - s1 <= L2STEP_CYC + 6});
    vid_host_model_i.send(4'h0, 8'h30, 1'b1);
    repeat (80) tick();
    chk("host_cmd", 8'h30, t1);
    chk("track_half", 8'h18, t2);
    // Fixed later-revision boot codes
    for (i = 1; i < 4; i++) begin
      reset_dut();
      wreg(REG_CTRL, 8'h85 | (8'(i) << 5));
      c = (i == 1) ? FIX_BOOT1 : (i == 2) ? FIX_BOOT2 : FIX_BOOT3;
      boot_run(c, c, 1'b1, s1, s2);
    end
    summarize();
  end
endmodule : boot_sequencer_tb

// ==== verif/vid_host_model.sv ====
// Partner model: processor side that issues voltage-ID commands
`timescale 1ns/1ns
module vid_host_model (
  // Clock
  input wire logic clock_i,
  // Command toward the block
  output logic vid_cmd_valid_o,
  output logic vid_cmd_from_host_o,
  output logic [3:0] vid_cmd_addr_o,
  output logic [7:0] vid_cmd_code_o
);
  // ----------
  // Idle state
  // ----------
  initial begin
    vid_cmd_valid_o = 1'b0;
    vid_cmd_from_host_o = 1'b0;
    vid_cmd_addr_o = 4'h0;
    vid_cmd_code_o = 8'h00;
  end

  // One-cycle command; fields scrambled after it so a stale value never matches
  task automatic send(input logic [3:0] a, input logic [7:0] c, input logic h);
    vid_cmd_addr_o <= a;
    vid_cmd_code_o <= c;
    vid_cmd_from_host_o <= h;
    vid_cmd_valid_o <= 1'b1;
    @(posedge clock_i);
    #1;
    vid_cmd_valid_o <= 1'b0;
    vid_cmd_addr_o <= ~a;
    vid_cmd_code_o <= ~c;
    vid_cmd_from_host_o <= ~h;
  endtask : send
endmodule : vid_host_model
